//--- verilog/disk_ctrl_self_test.sv
// Purpose: Self-test sequencer of the cartridge disk controller.
// Assumes: Datapath reports each segment through seg_result_i.
// Notes: Registers 2, 7 and 1 are read on the host read port.
`timescale 1ns/1ps
module disk_ctrl_self_test #(
	parameter int unsigned TIMER_CYCLES = diag_pkg::TIMER_CHECK_CYC
) (
	input  wire logic              sys_clk_i,
	input  wire logic              reset_n_i,
	input  wire logic              clk_en_i,
	input  wire logic              cmd_valid_i,
	input  wire logic [15:0]       cmd_word_i,
	input  wire logic              level0_n_i,
	input  wire logic              jumper_i,
	input  wire diag_pkg::seg_result_s seg_result_i,
	input  wire diag_pkg::host_rd_s    host_rd_i,
	output logic                   seg_start_o,
	output logic [4:0]             seg_index_o,
	output logic                   busy_o,
	output logic                   exec_o,
	output logic                   fault_o,
	output logic [15:0]            rd_data_o,
	output logic [15:0]            diag_status_o,
	output logic [7:0]             ctrl_status_low_o
);
	import diag_pkg::*;

	seq_state_e  state_q;
	logic [15:0] count_q;
	logic [15:0] diag_q;
	logic [7:0]  r7_low_q;
	logic [15:0] cmd_q;
	logic        fault_q;
	logic        long_q;
	logic        level0_q;
	logic [4:0]  seg_q;
	logic        start_q;
	logic        l0_level;
	logic        l0_event;
	logic        jmp_level;
	logic        timer_start;
	logic        timer_done;
	logic        is_dump;
	logic        seg_done;
	logic        seg_fail;
	logic        last_seg;

	// Level 0 request arrives from outside the clock domain.
	pulse_sync u_l0_sync (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.clk_en_i  (clk_en_i),
		.async_i   (~level0_n_i),
		.level_o   (l0_level),
		.rise_o    (l0_event)
	);

	// The jumper is a strap pin, synchronised as a level.
	pulse_sync u_jmp_sync (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.clk_en_i  (clk_en_i),
		.async_i   (jumper_i),
		.level_o   (jmp_level),
		.rise_o    ()
	);

	// Command timer check used only by the long test.
	cycle_timer #(
		.CYCLES (TIMER_CYCLES)
	) u_timer (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.clk_en_i  (clk_en_i),
		.start_i   (timer_start),
		.done_o    (timer_done)
	);

	assign is_dump     = (cmd_q == CMD_REG_DUMP);
	assign seg_done    = (state_q == ST_SEG) && seg_result_i.done && !start_q;
	assign seg_fail    = seg_done && !seg_result_i.pass;
	assign last_seg    = long_q ? (seg_q == SEG_LAST_LONG)
	                            : (seg_q == SEG_LAST_SHORT);
	assign timer_start = clk_en_i && (state_q == ST_SEG) && seg_done
	                     && seg_result_i.pass && last_seg && long_q; // RQ4

	// Sequencer: level 0 has priority over a host command.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q  <= ST_IDLE;
			long_q   <= 1'b0;
			level0_q <= 1'b0;
			seg_q    <= 5'h00;
			start_q  <= 1'b0;
			cmd_q    <= 16'h0000;
		end else if (clk_en_i) begin
			start_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (l0_event) begin
						cmd_q    <= CMD_REG_DUMP; // RQ15
						level0_q <= 1'b1;
						long_q   <= 1'b1;
						seg_q    <= 5'h00;
						if (jmp_level) begin // RQ3
							state_q <= ST_SEG; // RQ2
							start_q <= 1'b1;
						end else begin
							state_q <= ST_EXEC;
						end
					end else if (cmd_valid_i) begin
						cmd_q    <= cmd_word_i;
						level0_q <= 1'b0;
						state_q  <= ST_CHECK; // RQ1
					end
				end
				ST_CHECK: begin
					long_q <= is_dump; // RQ2
					seg_q  <= is_dump ? 5'h00 : 5'(LONG_ONLY_SEGS); // RQ4
					if (fault_q && !is_dump) begin // RQ13
						state_q <= ST_IDLE; // RQ14
					end else begin
						state_q <= ST_SEG;
						start_q <= 1'b1;
					end
				end
				ST_SEG: begin
					if (seg_fail) begin
						state_q <= ST_FAIL; // RQ7
					end else if (seg_done) begin
						if (last_seg) begin
							state_q <= long_q ? ST_TIMER : ST_EXEC;
						end else begin
							seg_q   <= seg_q + 5'h01; // RQ16
							start_q <= 1'b1;
						end
					end
				end
				ST_TIMER: begin
					if (timer_done) begin
						state_q <= ST_EXEC; // RQ4
					end
				end
				ST_EXEC: begin
					state_q <= ST_IDLE;
				end
				ST_FAIL: begin
					state_q <= ST_IDLE; // RQ7
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Status count; segment order gives counts of RQ17 to RQ22.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_q <= 16'h0000;
		end else if (clk_en_i) begin
			if (state_q == ST_IDLE) begin
				count_q <= 16'h0000;
			end else if (seg_done && seg_result_i.pass) begin
				count_q <= count_q + 16'h0001; // RQ6 RQ17 RQ18 RQ19 RQ20 RQ21 RQ22
			end
		end
	end

	// Register 2 and register 7 low byte updates.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			diag_q   <= 16'h0000;
			r7_low_q <= 8'h00;
		end else if (clk_en_i) begin
			if (state_q == ST_FAIL) begin
				r7_low_q <= STATUS_ERR_BYTE; // RQ12
				if (level0_q) begin
					diag_q <= {count_q[7:0], 8'h00}; // RQ10
				end else begin
					diag_q <= count_q; // RQ7 RQ11
				end
			end else if (state_q == ST_EXEC && long_q) begin
				diag_q <= level0_q ? DIAG_LEVEL0_OK : DIAG_DUMP_OK; // RQ8 RQ9
			end else if (state_q == ST_IDLE && cmd_valid_i && !l0_event) begin
				r7_low_q <= 8'h00;
			end
		end
	end

	// Fault latch persists until reset.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fault_q <= 1'b0;
		end else if (clk_en_i && state_q == ST_FAIL) begin
			fault_q <= 1'b1; // RQ13
		end
	end

	// Host read port, answered one cycle after the read strobe.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_o <= 16'h0000;
		end else if (clk_en_i && host_rd_i.rd) begin
			case (host_rd_i.addr)
				DIAG_STATUS_ADDR: rd_data_o <= diag_q; // RQ5
				CTRL_STATUS_ADDR: rd_data_o <= {8'h00, r7_low_q};
				CMD_ADDR:         rd_data_o <= cmd_q;
				default:          rd_data_o <= 16'h0000;
			endcase
		end
	end

	// Registered copies of state for the outputs.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			seg_start_o <= 1'b0;
			seg_index_o <= 5'h00;
			busy_o      <= 1'b0;
			exec_o      <= 1'b0;
		end else if (clk_en_i) begin
			seg_start_o <= start_q;
			seg_index_o <= seg_q;
			busy_o      <= (state_q != ST_IDLE);
			exec_o      <= (state_q == ST_EXEC);
		end
	end

	assign diag_status_o     = diag_q;
	assign ctrl_status_low_o = r7_low_q;
	assign fault_o           = fault_q;

	a_fail_sets_latch: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		(clk_en_i && state_q == ST_FAIL) |=> fault_q) // RQ13
		else $error("fault latch not set after failure");

	a_fail_r7_ff: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		(clk_en_i && state_q == ST_FAIL) |=> r7_low_q == 8'hFF) // RQ12
		else $error("status low byte not FF after failure");

	a_l0_upper_byte: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		(clk_en_i && state_q == ST_FAIL && level0_q)
		|=> diag_q == {$past(count_q[7:0]), 8'h00}) // RQ10
		else $error("level 0 failure count not in upper byte");

	a_latched_abort: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		(clk_en_i && state_q == ST_CHECK && fault_q && !is_dump)
		|=> state_q == ST_IDLE) // RQ14
		else $error("latched fault did not abort command");

	a_l0_ok_value: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		(clk_en_i && state_q == ST_EXEC && long_q && level0_q)
		|=> diag_q == 16'hFF00) // RQ9
		else $error("level 0 success value wrong");

	a_dump_ok_zero: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		(clk_en_i && state_q == ST_EXEC && long_q && !level0_q)
		|=> diag_q == 16'h0000) // RQ8
		else $error("register dump success value wrong");

	a_count_steps: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		(clk_en_i && seg_done && seg_result_i.pass)
		|=> count_q == $past(count_q) + 16'h0001) // RQ6
		else $error("status count did not advance");

	a_no_jump_skip: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		(clk_en_i && state_q == ST_IDLE && l0_event && !jmp_level)
		|=> state_q == ST_EXEC ##1 state_q == ST_IDLE) // RQ3
		else $error("level 0 without jumper ran diagnostics");

	a_l0_clears_cmd: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		(clk_en_i && state_q == ST_IDLE && l0_event) |=> cmd_q == 16'h0000) // RQ15
		else $error("command register not cleared on level 0");

	a_cmd_runs_test: assert property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		(clk_en_i && state_q == ST_IDLE && cmd_valid_i && !l0_event)
		|=> state_q == ST_CHECK) // RQ1
		else $error("command did not enter diagnostic check");

	c_fail_seen: cover property (@(posedge sys_clk_i)
		disable iff (!reset_n_i) state_q == ST_FAIL);
	c_long_done: cover property (@(posedge sys_clk_i)
		disable iff (!reset_n_i) state_q == ST_TIMER && timer_done);
	c_short_done: cover property (@(posedge sys_clk_i)
		disable iff (!reset_n_i) state_q == ST_EXEC && !long_q);
	c_latched_abort: cover property (@(posedge sys_clk_i)
		disable iff (!reset_n_i)
		state_q == ST_CHECK && fault_q && !is_dump);
endmodule

//--- verilog/diag_pkg.sv
// Purpose: Constants and types for the disk controller self-test sequencer.
// Assumes: One 100 MHz clock, asynchronous active-low reset.
// Notes: Segment checks are abstracted as pass/fail inputs from the datapath.
// Behaviour
// RQ1 - Short test runs before every host command.
// RQ2 - Long test on register dump or level 0.
// RQ3 - Level 0 without jumper skips diagnostics.
// RQ4 - Long test adds register test, timer check.
// RQ5 - Diagnostic status readable at register 2.
// RQ6 - Count advances on each passed segment.
// RQ7 - Error aborts, reports count, returns idle.
// RQ8 - Clean register dump leaves register 2 zero.
// RQ9 - Clean level 0 leaves register 2 FF00.
// RQ10 - Level 0 error puts count in upper byte.
// RQ11 - Normal command keeps register 2 unless error.
// RQ12 - Error sets status register 7 low byte FF.
// RQ13 - Error sets fault latch, checked each command.
// RQ14 - Latched fault aborts all but register dump.
// RQ15 - Level 0 trap clears command register to zero.
// RQ16 - Long segments: fives, A's, right shift.
// RQ17 - Left shift carry check counts next.
// RQ18 - FIFO fill and full check next.
// RQ19 - Start latch toggle check next.
// RQ20 - FIFO read mode and test mode check.
// RQ21 - Three headers: sync and read-sync flag.
// RQ22 - Per header CRC match, no rate error.
package diag_pkg;

	localparam logic [15:0] DIAG_STATUS_ADDR  = 16'hF804;
	localparam logic [15:0] CTRL_STATUS_ADDR  = 16'hF80E;
	localparam logic [15:0] CMD_ADDR          = 16'hF802;
	localparam logic [15:0] DIAG_DUMP_OK      = 16'h0000;
	localparam logic [15:0] DIAG_LEVEL0_OK    = 16'hFF00;
	localparam logic [7:0]  STATUS_ERR_BYTE   = 8'hFF;
	localparam logic [15:0] CMD_REG_DUMP      = 16'h0000;
	localparam int          HEADER_COUNT      = 3;
	localparam int          STEPS_PER_HEADER  = 4;
	localparam int          LONG_ONLY_SEGS    = 3;
	localparam int          SHORT_SEGS        = 4 + HEADER_COUNT * STEPS_PER_HEADER;
	// Short and long tests share one index space and end on the same
	// last header segment; the short test only starts further in.
	localparam logic [4:0]  SEG_LAST_SHORT    = 5'(LONG_ONLY_SEGS + SHORT_SEGS - 1);
	localparam logic [4:0]  SEG_LAST_LONG     = 5'(SHORT_SEGS + LONG_ONLY_SEGS - 1);
	localparam int          CLK_MHZ           = 100;
	localparam int          TIMER_CHECK_MS    = 200;
	localparam int          TIMER_CHECK_CYC   = TIMER_CHECK_MS * 1000 * CLK_MHZ;

	// Sequencer states, Gray along the register-dump long-test path from ST_IDLE to ST_EXEC.
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_CHECK = 3'b001,
		ST_SEG   = 3'b011,
		ST_TIMER = 3'b010,
		ST_EXEC  = 3'b110,
		ST_FAIL  = 3'b111
	} seq_state_e;

	// One segment result from the datapath.
	typedef struct packed {
		logic done;
		logic pass;
	} seg_result_s;

	// Host register read port.
	typedef struct packed {
		logic        rd;
		logic [15:0] addr;
	} host_rd_s;

endpackage

//--- verilog/pulse_sync.sv
// Purpose: Two-flop synchroniser with rising-edge pulse for external events.
// Assumes: Input is asynchronous to sys_clk_i.
// Notes: First flop feeds only the second flop.
`timescale 1ns/1ps
module pulse_sync (
	input  wire logic sys_clk_i,
	input  wire logic reset_n_i,
	input  wire logic clk_en_i,
	input  wire logic async_i,
	output logic      level_o,
	output logic      rise_o
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	// Two stages of synchronisation, then one for edge detection.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else if (clk_en_i) begin
			meta_q <= async_i;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level_o = sync_q;
	assign rise_o  = sync_q & ~prev_q & clk_en_i;
endmodule

//--- verilog/cycle_timer.sv
// Purpose: Down counter that signals completion of a fixed wait.
// Assumes: Start pulse loads the count.
// Notes: Used for the command timer check of the long test.
`timescale 1ns/1ps
module cycle_timer #(
	parameter int unsigned CYCLES = 20
) (
	input  wire logic sys_clk_i,
	input  wire logic reset_n_i,
	input  wire logic clk_en_i,
	input  wire logic start_i,
	output logic      done_o
);
	localparam int W = $clog2(CYCLES + 1);
	logic [W-1:0] cnt_q;
	logic         run_q;

	// Count down from CYCLES - 1 after a start pulse.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (clk_en_i) begin
			if (start_i) begin
				cnt_q <= W'(CYCLES - 1);
				run_q <= 1'b1;
			end else if (run_q && cnt_q != '0) begin
				cnt_q <= cnt_q - 1'b1;
			end else begin
				run_q <= 1'b0;
			end
		end
	end

	assign done_o = run_q && (cnt_q == '0) && !start_i;
endmodule

//--- tb/host_model.sv
// Purpose: Host processor model that issues commands, resets and reads.
// Assumes: Requests change on the falling edge of the clock.
// Notes: Level 0 is a short low pulse on the reset request line.
`timescale 1ns/1ps
module host_model (
	input  wire logic              sys_clk_i,
	input  wire logic [15:0]       rd_data_i,
	output logic                   cmd_valid_o,
	output logic [15:0]            cmd_word_o,
	output logic                   level0_n_o,
	output diag_pkg::host_rd_s     host_rd_o
);
	import diag_pkg::*;

	// Idle levels from time zero.
	initial begin
		cmd_valid_o = 1'b0;
		cmd_word_o = 16'h0000;
		level0_n_o = 1'b1;
		host_rd_o = '0;
	end

	// One-cycle command pulse with its word.
	task automatic send_cmd(input logic [15:0] word);
		@(negedge sys_clk_i);
		cmd_word_o = word;
		cmd_valid_o = 1'b1;
		@(negedge sys_clk_i);
		cmd_valid_o = 1'b0;
	endtask

	// Reset request held low long enough to pass the synchroniser.
	task automatic level0();
		@(negedge sys_clk_i);
		level0_n_o = 1'b0;
		repeat (4) @(negedge sys_clk_i);
		level0_n_o = 1'b1;
	endtask

	// Read strobe for one edge, data taken once it has settled.
	task automatic read(input logic [15:0] addr, output logic [15:0] data);
		@(negedge sys_clk_i);
		host_rd_o = '{rd: 1'b1, addr: addr};
		@(negedge sys_clk_i);
		host_rd_o.rd = 1'b0;
		@(negedge sys_clk_i);
		data = rd_data_i;
	endtask
endmodule

//--- tb/test_disk_ctrl_self_test.sv
// Purpose: Self-checking bench for the self-test sequencer.
// Assumes: Timer wait shortened through the TIMER_CYCLES parameter.
// Notes: A reference model tracks register 2, register 7 and the latch.
`timescale 1ns/1ps
module test_disk_ctrl_self_test;
	import diag_pkg::*;
	localparam int TCYC = 20;
	logic sys_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic jumper_i = 1'b0;
	logic cmd_valid, level0_n, seg_start_o, busy_o, exec_o, fault_o;
	logic [15:0] cmd_word, rd_data_o, diag_status_o, r;
	logic [4:0] seg_index_o;
	logic [7:0] ctrl_status_low_o;
	seg_result_s seg_res = '0;
	host_rd_s host_rd;
	int err_total = 0, check_count = 0, seed = 32'hbcab;
	int exp_idx, fail_idx, seg_seen, exec_seen, reg2_m = 0, fault_m = 0;
	time t_done, t_exec;

	always #5 sys_clk_i = ~sys_clk_i;

	disk_ctrl_self_test #(.TIMER_CYCLES(TCYC)) uut (
		.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
		.cmd_valid_i(cmd_valid), .cmd_word_i(cmd_word),
		.level0_n_i(level0_n), .jumper_i(jumper_i), .seg_result_i(seg_res),
		.host_rd_i(host_rd), .seg_start_o(seg_start_o),
		.seg_index_o(seg_index_o), .busy_o(busy_o), .exec_o(exec_o),
		.fault_o(fault_o), .rd_data_o(rd_data_o),
		.diag_status_o(diag_status_o),
		.ctrl_status_low_o(ctrl_status_low_o));

	host_model host (.sys_clk_i(sys_clk_i), .rd_data_i(rd_data_o),
		.cmd_valid_o(cmd_valid), .cmd_word_o(cmd_word),
		.level0_n_o(level0_n), .host_rd_o(host_rd));

	// Compares one value and counts the outcome.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Datapath stand-in: answers each segment after a random delay.
	always @(negedge sys_clk_i) begin
		if (seg_start_o === 1'b1) begin
			chk(16'(seg_index_o), 16'(exp_idx));
			seg_seen++;
			repeat (1 + ($random(seed) & 3)) @(negedge sys_clk_i);
			seg_res = '{done: 1'b1, pass: (exp_idx != fail_idx)};
			exp_idx++;
			@(negedge sys_clk_i);
			seg_res = '0;
			t_done = $time;
		end
	end

	// Counts command release pulses.
	always @(negedge sys_clk_i) begin
		if (exec_o === 1'b1) begin
			exec_seen++;
			t_exec = $time;
		end
	end

	// Runs one command or level 0 request and checks its outcome.
	task automatic do_op(input int lvl, input logic [15:0] word,
			input logic jmp, input int fail);
		int first, n_exp, i;
		bit lng, skip, blk;
		lng = (lvl == 1) || (word == CMD_REG_DUMP);
		first = lng ? 0 : 3;
		skip = (lvl == 1) && !jmp;
		blk = (fault_m == 1) && (lvl == 0) && (word != CMD_REG_DUMP);
		@(negedge sys_clk_i);
		jumper_i = jmp;
		repeat (4) @(negedge sys_clk_i);
		exp_idx = first;
		fail_idx = fail;
		seg_seen = 0;
		exec_seen = 0;
		if (lvl == 1) host.level0();
		else host.send_cmd(word);
		repeat (4) @(negedge sys_clk_i);
		for (i = 0; i < 3000 && busy_o !== 1'b0; i++) @(negedge sys_clk_i);
		repeat (3) @(negedge sys_clk_i);
		n_exp = (skip || blk) ? 0 : (fail >= 0 ? fail - first + 1 : 19 - first);
		chk(16'(seg_seen), 16'(n_exp));
		chk(16'(exec_seen), 16'((fail >= 0 || blk) ? 0 : 1));
		// A skipped level 0 still completes cleanly and reports FF00.
		if (skip) reg2_m = 16'hFF00;
		if (!skip && !blk) begin
			if (fail >= 0) begin
				reg2_m = (lvl == 1) ? (fail - first) << 8 : fail - first;
				fault_m = 1;
			end else if (lng) reg2_m = (lvl == 1) ? 16'hFF00 : 16'h0000;
			host.read(CTRL_STATUS_ADDR, r);
			chk(r, (fail >= 0) ? 16'h00FF : 16'h0000);
			chk(16'(ctrl_status_low_o), (fail >= 0) ? 16'h00FF : 16'h0000);
			if (lng && fail < 0) chk(16'(t_exec - t_done >= 10 * TCYC), 1);
		end
		host.read(DIAG_STATUS_ADDR, r);
		chk(r, 16'(reg2_m));
		chk(diag_status_o, 16'(reg2_m));
		chk(16'(fault_o), 16'(fault_m));
		if (lvl == 1 && jmp) begin
			host.read(CMD_ADDR, r);
			chk(r, CMD_REG_DUMP);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// Cuts a hung run short.
	initial begin
		#400000;
		err_total++;
		stop_test();
	end

	// Main sequence: clean runs, skips, failures and latched aborts.
	initial begin
		repeat (4) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		reset_n_i = 1'b1;
		host.read(16'hF8FE, r);
		chk(r, 16'h0000);
		host.read(DIAG_STATUS_ADDR, r);
		chk(r, 16'h0000);
		do_op(0, 16'($random(seed)) | 16'h0001, 0, -1);
		do_op(0, CMD_REG_DUMP, 0, -1);
		do_op(1, 16'h0000, 0, -1);
		do_op(1, 16'h0000, 1, -1);
		do_op(0, 16'($random(seed)) | 16'h0001, 0, -1);
		do_op(0, 16'h0101, 0, 3 + ($random(seed) & 15));
		do_op(0, 16'($random(seed)) | 16'h0001, 0, -1);
		do_op(0, CMD_REG_DUMP, 0, -1);
		do_op(1, 16'h0000, 1, $random(seed) & 15);
		stop_test();
	end
endmodule
